/* File: verilog/adc_cal_sequencer.sv */
// Purpose: Calibration and conversion sequencer with AXI4-Lite registers
// Assumes: Modulator clock and pins asynchronous to aclk
// Notes:   Summary of operation below
//
// Summary of operation
// - Three calibrations chosen by writing the operating-mode field.
// - Each result has offset subtracted, then gain applied, before data register.
// - Starting a calibration drives the data-out/ready pin high, unless a corrected result arrives in the same cycle.
// - Finished calibration loads the coefficient of the mode just run.
// - Completion sets ready flag; pin driven low only while chip select low.
// - After calibration the mode returns to idle by itself.
// - Internal zero-scale calibration switches zero input onto converter.
// - Offset calibrations take two conversion cycles.
// - Full-scale calibration takes two cycles, stores gain coefficient.
`default_nettype none
`include "cal_seq_cfg.svh"
module adc_cal_sequencer
  import cal_seq_pkg::*;
#(
  parameter int DATA_W     = 24,
  parameter int CONV_EDGES = `CONV_EDGES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              mod_clk,
  input  wire logic [DATA_W-1:0] raw_result,
  input  wire logic              cs_n,
  output var  logic              dout_rdy,
  output var  logic              dout_rdy_oe_n,
  output var  logic              zero_input_sel,
  output var  logic              irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic              aw_full;
    logic [7:0]        aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        op_mode;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] gain;
    logic [DATA_W-1:0] data;
    seq_state_type     state;
    logic [15:0]       edge_cnt;
    logic [1:0]        pass;
    logic              mclk_s1;
    logic              mclk_s2;
    logic              mclk_s3;
    logic              cs_s1;
    logic              cs_s2;
    logic [DATA_W-1:0] raw_s1;
    logic [DATA_W-1:0] raw_s2;
    logic              corr_start;
    logic [DATA_W-1:0] corr_raw;
    logic              pin;
    logic              oe_n;
    logic              zero_sel;
    logic              irq;
  } seq_type;

  seq_type s_r;
  seq_type s_nxt;
  logic              corr_done;
  logic [DATA_W-1:0] corr_result;
  logic              conv_tick;
  logic              mode_wr;
  logic              cal_end;
  logic [31:0]       rd_word;
  logic [31:0]       wr_word;
  logic              rd_hit;
  logic              wr_hit;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_cal(input logic [2:0] m);
    return (m == `MODE_ZS_INT) || (m == `MODE_ZS_SYS) || (m == `MODE_FS_SYS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[8*i +: 8] = d[8*i +: 8];
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // Correction unit
  // ----------------------------------------
  result_corrector #(
    .DATA_W (DATA_W)
  ) u_corr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s_r.corr_start),
    .raw     (s_r.corr_raw),
    .offset  (s_r.offset),
    .gain    (s_r.gain),
    .done    (corr_done),
    .result  (corr_result)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.mclk_s1 = mod_clk;
    s_nxt.mclk_s2 = s_r.mclk_s1;
    s_nxt.mclk_s3 = s_r.mclk_s2;
    s_nxt.cs_s1 = cs_n;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.raw_s1 = raw_result;
    s_nxt.raw_s2 = s_r.raw_s1;
    s_nxt.oe_n = s_r.cs_s2;
    s_nxt.corr_start = 1'b0;
    rd_word = 32'h00000000;
    wr_word = 32'h00000000;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    mode_wr = 1'b0;
    cal_end = 1'b0;

    // Conversion cycle timing from modulator clock edges
    conv_tick = 1'b0;
    if (s_r.mclk_s2 && !s_r.mclk_s3) begin
      if (s_r.edge_cnt == 16'(CONV_EDGES - 1)) begin
        s_nxt.edge_cnt = '0;
        conv_tick = (s_r.state == ST_CONV) || (s_r.state == ST_CAL);
      end else begin
        s_nxt.edge_cnt = s_r.edge_cnt + 16'h0001;
      end
    end

    // Write channel
    if (s_axi_awvalid && !s_r.aw_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_full && !s_r.bvalid) begin
      s_nxt.w_full = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.aw_addr == `ADDR_MODE) begin
        if (s_r.w_strb[0]) begin
          s_nxt.op_mode = s_r.w_data[2:0];
          mode_wr = 1'b1;
        end
      end else if (s_r.aw_addr == `ADDR_MASK) begin
        wr_word = merge({30'h0, s_r.mask}, s_r.w_data, s_r.w_strb);
        s_nxt.mask = wr_word[1:0];
      end else if (s_r.aw_addr == `ADDR_OFFSET) begin
        wr_word = merge(32'(s_r.offset), s_r.w_data, s_r.w_strb);
        s_nxt.offset = wr_word[DATA_W-1:0];
      end else if (s_r.aw_addr == `ADDR_GAIN) begin
        wr_word = merge(32'(s_r.gain), s_r.w_data, s_r.w_strb);
        s_nxt.gain = wr_word[DATA_W-1:0];
      end else if (s_r.aw_addr == `ADDR_STATUS || s_r.aw_addr == `ADDR_DATA) begin
        wr_hit = 1'b1;
      end else begin
        wr_hit = 1'b0;
      end
      s_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Read channel
    if (s_axi_araddr == `ADDR_MODE) begin
      rd_word = {29'h0, s_r.op_mode};
    end else if (s_axi_araddr == `ADDR_STATUS) begin
      rd_word = {27'h0, s_r.state != ST_IDLE, 2'h0, s_r.status};
    end else if (s_axi_araddr == `ADDR_MASK) begin
      rd_word = {30'h0, s_r.mask};
    end else if (s_axi_araddr == `ADDR_OFFSET) begin
      rd_word = 32'(s_r.offset);
    end else if (s_axi_araddr == `ADDR_GAIN) begin
      rd_word = 32'(s_r.gain);
    end else if (s_axi_araddr == `ADDR_DATA) begin
      rd_word = 32'(s_r.data);
    end else begin
      rd_hit = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (s_axi_araddr == `ADDR_STATUS) begin
        s_nxt.status = 2'h0;
      end
      if (s_axi_araddr == `ADDR_DATA && s_r.state != ST_CAL) begin
        s_nxt.pin = 1'b1;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // Sequencer
    case (s_r.state)
      ST_IDLE: begin
        s_nxt.zero_sel = 1'b0;
      end
      ST_START: begin
        s_nxt.edge_cnt = '0;
        s_nxt.pass = '0;
        if (is_cal(s_r.op_mode)) begin
          s_nxt.state = ST_CAL;
          s_nxt.pin = 1'b1;
          s_nxt.zero_sel = (s_r.op_mode == `MODE_ZS_INT);
        end else if (s_r.op_mode == `MODE_CONT || s_r.op_mode == `MODE_SINGLE) begin
          s_nxt.state = ST_CONV;
          s_nxt.zero_sel = 1'b0;
        end else begin
          s_nxt.state = ST_IDLE;
          s_nxt.zero_sel = 1'b0;
        end
      end
      ST_CONV: begin
        if (conv_tick) begin
          s_nxt.corr_start = 1'b1;
          s_nxt.corr_raw = s_r.raw_s2;
          if (s_r.op_mode == `MODE_SINGLE) begin
            s_nxt.state = ST_IDLE;
            s_nxt.op_mode = `MODE_IDLE;
          end
        end
      end
      ST_CAL: begin
        if (conv_tick) begin
          if (s_r.pass == `CAL_CONVS - 2'h1) begin
            cal_end = 1'b1;
            if (s_r.op_mode == `MODE_FS_SYS) begin
              s_nxt.gain = s_r.raw_s2 - s_r.offset;
            end else begin
              s_nxt.offset = s_r.raw_s2;
            end
            s_nxt.pin = 1'b0;
            s_nxt.zero_sel = 1'b0;
            s_nxt.state = ST_IDLE;
            s_nxt.op_mode = `MODE_IDLE;
          end else begin
            s_nxt.pass = s_r.pass + 2'h1;
          end
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase
    if (mode_wr) begin
      s_nxt.state = ST_START;
    end

    // Corrected result into data register
    if (corr_done) begin
      s_nxt.data = corr_result;
      s_nxt.pin = 1'b0;
    end

    // Sticky events, set wins over read clear
    if (cal_end) begin
      s_nxt.status[`ST_CAL_BIT] = 1'b1;
    end
    if (corr_done) begin
      s_nxt.status[`ST_CONV_BIT] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.arready <= 1'b1;
      s_r.op_mode <= `MODE_IDLE;
      s_r.offset <= `OFFSET_RST;
      s_r.gain <= `GAIN_RST;
      s_r.state <= ST_IDLE;
      s_r.pin <= 1'b1;
      s_r.oe_n <= 1'b1;
      s_r.cs_s1 <= 1'b1;
      s_r.cs_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = !s_r.aw_full && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_full && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign dout_rdy = s_r.pin;
  assign dout_rdy_oe_n = s_r.oe_n;
  assign zero_input_sel = s_r.zero_sel;
  assign irq = s_r.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mode_dispatch: assert property (
    s_r.state == ST_START && !mode_wr && s_r.op_mode == `MODE_ZS_SYS |=> s_r.state == ST_CAL
  ) else $error("system zero-scale not started");

  a_corr_data: assert property (
    corr_done |=> s_r.data == $past(corr_result) && s_r.status[`ST_CONV_BIT]
  ) else $error("corrected result not stored");

  a_start_pin: assert property (
    s_r.state == ST_START && !mode_wr && is_cal(s_r.op_mode) |=> s_r.pin
  ) else $error("pin not high at calibration start");

  a_offset_load: assert property (
    cal_end && s_r.op_mode != `MODE_FS_SYS && !mode_wr |=> s_r.offset == $past(s_r.raw_s2)
  ) else $error("offset coefficient not loaded");

  a_ready_flag: assert property (
    cal_end ##1 !corr_done |-> s_r.status[`ST_CAL_BIT] && !s_r.pin
  ) else $error("ready flag or pin wrong at end");

  a_pin_enable: assert property (
    ##2 s_r.oe_n == $past(cs_n, 3)
  ) else $error("pin enable does not follow chip select");

  a_idle_return: assert property (
    cal_end && !mode_wr |=> s_r.state == ST_IDLE && s_r.op_mode == `MODE_IDLE
  ) else $error("no return to idle");

  a_zero_input: assert property (
    s_r.zero_sel |-> s_r.state == ST_CAL && s_r.op_mode == `MODE_ZS_INT || mode_wr
  ) else $error("zero input outside internal calibration");

  a_two_convs: assert property (
    s_r.state == ST_CAL && conv_tick && s_r.pass == 2'h0 && !mode_wr |=> s_r.state == ST_CAL
  ) else $error("calibration ended after one conversion");

  a_gain_load: assert property (
    cal_end && s_r.op_mode == `MODE_FS_SYS && !mode_wr
      |=> s_r.gain == $past(s_r.raw_s2 - s_r.offset)
  ) else $error("gain coefficient not loaded");
endmodule
`default_nettype wire

/* File: verilog/cal_seq_cfg.svh */
// Purpose: Constants of the calibration sequencer
// Assumes: 32-bit AXI4-Lite register bus
// Notes:   Offsets are byte addresses
`ifndef CAL_SEQ_CFG_SVH
`define CAL_SEQ_CFG_SVH
`define ADDR_MODE      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_MASK      8'h08
`define ADDR_OFFSET    8'h0C
`define ADDR_GAIN      8'h10
`define ADDR_DATA      8'h14
`define MODE_CONT      3'h0
`define MODE_SINGLE    3'h1
`define MODE_IDLE      3'h2
`define MODE_PDOWN     3'h3
`define MODE_ZS_INT    3'h4
`define MODE_ZS_SYS    3'h6
`define MODE_FS_SYS    3'h7
`define ST_CAL_BIT     0
`define ST_CONV_BIT    1
`define ST_BUSY_BIT    4
`define OFFSET_RST     24'h800000
`define GAIN_RST       24'h400000
`define GAIN_SHIFT     22
`define MID_CODE       24'h800000
`define CAL_CONVS      2'h2
`define CONV_EDGES     16
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* File: verilog/cal_seq_pkg.sv */
// Purpose: Types of the calibration sequencer
// Assumes: Nothing
// Notes:   Constants live in cal_seq_cfg.svh
`default_nettype none
package cal_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_CONV  = 2'b10,
    ST_CAL   = 2'b11
  } seq_state_type;
endpackage
`default_nettype wire

/* File: verilog/result_corrector.sv */
// Purpose: Offset subtract and gain multiply of one raw result
// Assumes: Offset-binary raw codes
// Notes:   Two-cycle latency, result saturates
`default_nettype none
`include "cal_seq_cfg.svh"
module result_corrector #(
  parameter int DATA_W = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic [DATA_W-1:0] raw,
  input  wire logic [DATA_W-1:0] offset,
  input  wire logic [DATA_W-1:0] gain,
  output var  logic              done,
  output var  logic [DATA_W-1:0] result
);
  typedef struct packed {
    logic              stage1;
    logic signed [DATA_W:0] diff;
    logic [DATA_W-1:0] gain;
    logic              done;
    logic [DATA_W-1:0] result;
  } corr_type;

  corr_type c_r;
  corr_type c_nxt;
  logic signed [2*DATA_W+1:0] prod;
  logic signed [2*DATA_W+1:0] scaled;

  always_comb begin
    c_nxt = c_r;
    prod = c_r.diff * $signed({1'b0, c_r.gain});
    scaled = (prod >>> `GAIN_SHIFT) + $signed({{(DATA_W+2){1'b0}}, `MID_CODE});
    c_nxt.stage1 = start;
    c_nxt.done = c_r.stage1;
    if (start) begin
      c_nxt.diff = $signed({1'b0, raw}) - $signed({1'b0, offset});
      c_nxt.gain = gain;
    end
    if (c_r.stage1) begin
      if (scaled < 0) begin
        c_nxt.result = '0;
      end else if (scaled > $signed({{(DATA_W+2){1'b0}}, {DATA_W{1'b1}}})) begin
        c_nxt.result = '1;
      end else begin
        c_nxt.result = scaled[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign done = c_r.done;
  assign result = c_r.result;
endmodule
`default_nettype wire

/* File: tb/conv_front_model.sv */
// Purpose: Converter front end seen by the calibration sequencer
// Assumes: Modulator clock runs free, 160 ns period
// Notes:   Internal zero input replaces the applied level
`default_nettype none
`include "cal_seq_cfg.svh"
module conv_front_model #(
  parameter int DATA_W = 24
) (
  input  wire logic              zero_sel,
  input  wire logic [DATA_W-1:0] level,
  output var  logic              mod_clk,
  output wire logic [DATA_W-1:0] raw
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Modulator clock
  // ----------------------------------------
  initial begin
    mod_clk = 1'h0;
    forever #80 mod_clk = ~mod_clk;
  end

  // ----------------------------------------
  // Input switch
  // ----------------------------------------
  // Zero code while the internal zero is selected, else the applied level
  assign raw = zero_sel ? `MID_CODE : level;
endmodule
`default_nettype wire

/* File: tb/adc_calibration_sequencer_tb.sv */
// Purpose: Self-checking bench of the calibration sequencer
// Assumes: Short conversion cycle through CONV_EDGES
// Notes:   Register accesses go through bus tasks; cs_n and level are driven directly
`default_nettype none
`include "cal_seq_cfg.svh"
module adc_calibration_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CE  = 2;
  localparam int LIM = 400;
  logic        aclk     = 1'h0;
  logic        aresetn  = 1'h0;
  logic [7:0]  awaddr   = 8'h00;
  logic        awvalid  = 1'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic [7:0]  araddr   = 8'h00;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic        cs_n     = 1'h1;
  logic [23:0] level    = 24'h800000;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        dout_rdy, dout_rdy_oe_n, zero_input_sel, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  wire         mod_clk;
  wire  [23:0] raw_result;
  int          failures = 0;
  int          checked  = 0;
  int          dur;
  // Calibration table, zero-scale runs first
  logic [2:0]  cm [3] = '{`MODE_ZS_INT, `MODE_ZS_SYS, `MODE_FS_SYS};
  logic [23:0] lv [3] = '{24'h123456, 24'h800100, 24'hA00100};
  logic        cs [3] = '{1'h1, 1'h0, 1'h0};
  logic        mk [3] = '{1'h1, 1'h0, 1'h1};
  logic [7:0]  ca [3] = '{`ADDR_OFFSET, `ADDR_OFFSET, `ADDR_GAIN};
  logic [31:0] ce [3] = '{`MID_CODE, 32'h800100, 32'h200000};
  logic [7:0]  ra [7] = '{`ADDR_MODE, `ADDR_STATUS, `ADDR_MASK, `ADDR_OFFSET,
                          `ADDR_GAIN, `ADDR_DATA, 8'h18};
  logic [31:0] re [7] = '{32'h2, 32'h0, 32'h0, `OFFSET_RST, `GAIN_RST, 32'h0, 32'h0};
  logic [1:0]  rr [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, `RESP_SLVERR};

  always #10 aclk = ~aclk;

  conv_front_model FRONT (
    .zero_sel (zero_input_sel),
    .level    (level),
    .mod_clk  (mod_clk),
    .raw      (raw_result)
  );

  adc_cal_sequencer #(
    .DATA_W     (24),
    .CONV_EDGES (CE)
  ) DUT (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (awaddr),
    .s_axi_awvalid  (awvalid),
    .s_axi_awready  (awready),
    .s_axi_wdata    (wdata),
    .s_axi_wstrb    (4'hF),
    .s_axi_wvalid   (wvalid),
    .s_axi_wready   (wready),
    .s_axi_bresp    (bresp),
    .s_axi_bvalid   (bvalid),
    .s_axi_bready   (bready),
    .s_axi_araddr   (araddr),
    .s_axi_arvalid  (arvalid),
    .s_axi_arready  (arready),
    .s_axi_rdata    (rdata),
    .s_axi_rresp    (rresp),
    .s_axi_rvalid   (rvalid),
    .s_axi_rready   (rready),
    .mod_clk        (mod_clk),
    .raw_result     (raw_result),
    .cs_n           (cs_n),
    .dout_rdy       (dout_rdy),
    .dout_rdy_oe_n  (dout_rdy_oe_n),
    .zero_input_sel (zero_input_sel),
    .irq            (irq)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= d;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (n = 0; n < LIM; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid === 1'h1 && bready) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
    if (n == LIM) begin
      failures++;
      summarize();
    end
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (n = 0; n < LIM; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1 && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
    if (n == LIM) begin
      failures++;
      summarize();
    end
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd, rsp);
    check(rd, e);
  endtask

  // Waits for an interrupt or the selected pin going low
  task automatic wait_done;
    dur = 0;
    while (dur < LIM && irq !== 1'h1 && !(cs_n == 1'h0 && dout_rdy === 1'h0)) begin
      @(posedge aclk);
      dur++;
    end
    if (dur == LIM) begin
      failures++;
      summarize();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      axi_rd(ra[i], rd, rsp);
      check(rd, re[i]);
      check(rsp, rr[i]);
    end
    axi_wr(`ADDR_DATA, 32'hFFFFFF, rsp);
    check(rsp, `RESP_OKAY);
    axi_wr(8'h1C, 32'h0, rsp);
    check(rsp, `RESP_SLVERR);
    rd_chk(`ADDR_DATA, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      cs_n  <= cs[i];
      level <= lv[i];
      axi_wr(`ADDR_MASK, {31'h0, mk[i]}, rsp);
      axi_wr(`ADDR_MODE, {29'h0, cm[i]}, rsp);
      repeat (2) @(posedge aclk);
      check(dout_rdy, 1'h1);
      check(zero_input_sel, cm[i] == `MODE_ZS_INT);
      wait_done();
      check(dur >= (2 * CE - 1) * 8 - 4 && dur <= 2 * CE * 8 + 8, 1'h1);
      @(posedge aclk);
      check(irq, mk[i]);
      check(dout_rdy_oe_n, cs[i]);
      check(zero_input_sel, 1'h0);
      if (!cs[i]) check(dout_rdy, 1'h0);
      rd_chk(`ADDR_STATUS, 32'h1);
      rd_chk(`ADDR_STATUS, 32'h0);
      check(irq, 1'h0);
      rd_chk(`ADDR_MODE, `MODE_IDLE);
      rd_chk(ca[i], ce[i]);
      $display("test calibration %0d done", i);
    end
    level <= 24'h900100;
    cs_n  <= 1'h1;
    axi_wr(`ADDR_MASK, 32'h2, rsp);
    axi_wr(`ADDR_MODE, {29'h0, `MODE_SINGLE}, rsp);
    wait_done();
    repeat (2) @(posedge aclk);
    rd_chk(`ADDR_STATUS, 32'h2);
    rd_chk(`ADDR_DATA, 32'h880000);
    $display("test correction done");
    summarize();
  end
endmodule
`default_nettype wire
